// [inc/mba_consts.svh]
`ifndef MBA_CONSTS_SVH
`define MBA_CONSTS_SVH

// register indices on the plain register port
`define MBA_REG_X_START      3'h0
`define MBA_REG_X_END        3'h1
`define MBA_REG_Y_START      3'h2
`define MBA_REG_Y_END        3'h3
`define MBA_REG_CONTROL      3'h4
`define MBA_REG_PIVOT        3'h5
`define MBA_REG_TABLE_PAGE   3'h6
`define MBA_REG_WINDOW_PAGE  3'h7
`define MBA_REG_STATUS_ADDR  4'h8

// control register fields; the reversal enable bit sits in the pivot register
`define MBA_X_SEL_LSB        0
`define MBA_Y_SEL_LSB        4
`define MBA_REV_SEL_LSB      8
`define MBA_Y_EN_BIT         14
`define MBA_X_EN_BIT         15
`define MBA_REV_EN_BIT       15
`define MBA_SEL_OFF          4'hf

// reset values
`define MBA_RST_WORD         16'h0000
`define MBA_RST_CONTROL      16'h0fff
`define MBA_RST_PAGE         8'h00

`endif

// [inc/mba_pkg.sv]
package mba_pkg;

    // addressing modes from the execution pipeline
    typedef enum logic [2:0] {
        MBA_MODE_DIRECT   = 3'h0,
        MBA_MODE_PLAIN    = 3'h1,
        MBA_MODE_POST_INC = 3'h2,
        MBA_MODE_POST_DEC = 3'h3,
        MBA_MODE_PRE_INC  = 3'h4,
        MBA_MODE_PRE_DEC  = 3'h5,
        MBA_MODE_OFFSET   = 3'h6
    } mba_mode_t;

    // one address request from the pipeline
    typedef struct packed {
        logic        valid;
        logic [3:0]  reg_sel;
        logic [15:0] pointer;
        logic [15:0] modifier;
        mba_mode_t   mode;
        logic        byte_op;
    } mba_req_t;

    // answer to one request
    typedef struct packed {
        logic        valid;
        logic [15:0] ea;
        logic        write_back;
        logic [15:0] wb_value;
    } mba_rsp_t;

    // corrected address state machine is trivial: single stage
    typedef enum logic [1:0] {
        MBA_ST_IDLE = 2'b01,
        MBA_ST_BUSY = 2'b10
    } mba_state_t;

endpackage : mba_pkg

// [rtl/mba_agu.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mba_consts.svh"

module mba_agu (
    // clock, reset, enable
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    input  wire logic             ce_in,
    // register port
    input  wire logic [3:0]       reg_addr_in,
    input  wire logic [15:0]      reg_wdata_in,
    input  wire logic             reg_wr_in,
    input  wire logic             reg_rd_in,
    output logic      [15:0]      reg_rdata_out,
    // core control window enable
    input  wire logic             program_window_enable_in,
    // X read, X write, Y requests
    input  wire mba_pkg::mba_req_t xr_req_in,
    input  wire mba_pkg::mba_req_t xw_req_in,
    input  wire mba_pkg::mba_req_t y_req_in,
    output mba_pkg::mba_rsp_t     xr_rsp_out,
    output mba_pkg::mba_rsp_t     xw_rsp_out,
    output mba_pkg::mba_rsp_t     y_rsp_out,
    // program space construction
    input  wire logic             table_req_in,
    input  wire logic [15:0]      table_ea_in,
    input  wire logic             window_req_in,
    input  wire logic             window_wr_in,
    input  wire logic [15:0]      window_ea_in,
    output logic      [23:0]      prog_addr_out,
    output logic                  prog_valid_out,
    output logic                  prog_config_out,
    output logic                  prog_low_word_out,
    output logic                  window_fault_out
);

    // software registers
    logic [15:0] x_circular_start;
    logic [15:0] x_circular_end;
    logic [15:0] y_circular_start;
    logic [15:0] y_circular_end;
    logic [15:0] circular_reverse_control;
    logic [15:0] reverse_pivot_control;
    logic [7:0]  program_table_page;
    logic [7:0]  program_window_page;
    // count of cycles with an X address correction, shows own state
    logic [15:0] wrap_count;

    // decoded control fields
    logic [3:0]  x_pointer_select;
    logic [3:0]  y_pointer_select;
    logic [3:0]  reverse_pointer_select;
    logic        x_circular_enable;
    logic        y_circular_enable;
    logic        reverse_enable;
    logic [14:0] pivot_modifier;

    assign x_pointer_select       = circular_reverse_control[`MBA_X_SEL_LSB +: 4];
    assign y_pointer_select       = circular_reverse_control[`MBA_Y_SEL_LSB +: 4];
    assign reverse_pointer_select = circular_reverse_control[`MBA_REV_SEL_LSB +: 4];
    assign x_circular_enable      = circular_reverse_control[`MBA_X_EN_BIT];
    assign y_circular_enable      = circular_reverse_control[`MBA_Y_EN_BIT];
    assign reverse_enable         = reverse_pivot_control[`MBA_REV_EN_BIT];
    assign pivot_modifier         = reverse_pivot_control[14:0];

    // X and Y modulo activity, one buffer each
    logic x_mod_on;
    logic y_mod_on;
    assign x_mod_on = (x_pointer_select != `MBA_SEL_OFF) && x_circular_enable;
    assign y_mod_on = (y_pointer_select != `MBA_SEL_OFF) && y_circular_enable;

    // raw effective address and pointer update for a mode
    function automatic logic [31:0] raw_calc(input mba_pkg::mba_req_t r);
        logic [15:0] ea;
        logic [15:0] nxt;
        ea  = r.pointer;
        nxt = r.pointer;
        case (r.mode)
            mba_pkg::MBA_MODE_POST_INC: begin
                nxt = r.pointer + r.modifier;
            end
            mba_pkg::MBA_MODE_POST_DEC: begin
                nxt = r.pointer - r.modifier;
            end
            mba_pkg::MBA_MODE_PRE_INC: begin
                ea  = r.pointer + r.modifier;
                nxt = ea;
            end
            mba_pkg::MBA_MODE_PRE_DEC: begin
                ea  = r.pointer - r.modifier;
                nxt = ea;
            end
            mba_pkg::MBA_MODE_OFFSET: begin
                ea  = r.pointer + r.modifier;
            end
            default: begin
                ea  = r.pointer;
            end
        endcase
        return {ea, nxt};
    endfunction : raw_calc

    // modulo correction; compares with <, > so jumps past a bound wrap too
    function automatic logic [15:0] wrap(input logic [15:0] a,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi,
                                         input logic        word_only);
        logic [15:0] len;
        logic [15:0] v;
        logic [15:0] res;
        len = hi - lo + 16'h0001;
        v   = a;
        res = a;
        if (word_only) begin
            v = {a[15:1], 1'b0};
        end
        res = v;
        // checking both ends lets buffers of any length run either way;
        // no buffer is tied to the end it moves toward
        if (v > hi) begin
            res = v - len;
        end else if (v < lo) begin
            res = v + len;
        end
        return res;
    endfunction : wrap

    // does the request pointer need the modulo unit
    function automatic logic hits(input mba_pkg::mba_req_t r,
                                  input logic [3:0]        sel,
                                  input logic              on);
        return on && r.valid && (r.reg_sel == sel)
               && (r.mode != mba_pkg::MBA_MODE_DIRECT);
    endfunction : hits

    // write-back only for modifying modes
    function automatic logic modifies(input mba_pkg::mba_mode_t m);
        return (m == mba_pkg::MBA_MODE_POST_INC) || (m == mba_pkg::MBA_MODE_POST_DEC)
            || (m == mba_pkg::MBA_MODE_PRE_INC) || (m == mba_pkg::MBA_MODE_PRE_DEC);
    endfunction : modifies

    // 16-bit bit reversal of the pivot, plus the byte scaling shift
    function automatic logic [15:0] rev_add(input logic [15:0] p,
                                            input logic [14:0] piv);
        logic [15:0] s;
        logic [15:0] r;
        s = {piv, 1'b0};
        r = 16'h0000;
        // reversed-carry add: reverse, add, reverse back
        for (int i = 0; i < 16; i++) begin
            r[i] = p[15 - i];
        end
        s = {<<{s}};
        r = r + s;
        r = {<<{r}};
        return {r[15:1], 1'b0};
    endfunction : rev_add

    // combinational results for each unit
    logic [31:0] xr_raw;
    logic [31:0] xw_raw;
    logic [31:0] y_raw;
    logic        xr_hit;
    logic        xw_hit;
    logic        y_hit;
    logic        rev_on;
    logic [15:0] next_xr_ea;
    logic [15:0] next_xr_wb;
    logic [15:0] next_xw_ea;
    logic [15:0] next_xw_wb;
    logic [15:0] next_y_ea;
    logic [15:0] next_y_wb;
    logic [15:0] rev_addr;

    assign xr_raw = raw_calc(xr_req_in);
    assign xw_raw = raw_calc(xw_req_in);
    assign y_raw  = raw_calc(y_req_in);
    assign xr_hit = hits(xr_req_in, x_pointer_select, x_mod_on);
    assign y_hit  = hits(y_req_in, y_pointer_select, y_mod_on);

    // reversal: X write, word data, pre/post increment only
    assign rev_on = xw_req_in.valid && reverse_enable
                    && (reverse_pointer_select != `MBA_SEL_OFF)
                    && (xw_req_in.reg_sel == reverse_pointer_select)
                    && !xw_req_in.byte_op
                    && ((xw_req_in.mode == mba_pkg::MBA_MODE_PRE_INC)
                     || (xw_req_in.mode == mba_pkg::MBA_MODE_POST_INC));
    // reversal takes the write unit away from modulo
    assign xw_hit = hits(xw_req_in, x_pointer_select, x_mod_on) && !rev_on;
    assign rev_addr = rev_add(xw_req_in.pointer, pivot_modifier);

    // X read unit keeps modulo even with reversal on
    always_comb begin
        next_xr_ea = xr_hit ? wrap(xr_raw[31:16], x_circular_start, x_circular_end, 1'b0)
                            : xr_raw[31:16];
        next_xr_wb = xr_hit ? wrap(xr_raw[15:0], x_circular_start, x_circular_end, 1'b0)
                            : xr_raw[15:0];
    end

    // X write unit: reversal, modulo or plain
    always_comb begin
        if (rev_on) begin
            // pre-increment uses the new address, post keeps the old
            next_xw_ea = (xw_req_in.mode == mba_pkg::MBA_MODE_PRE_INC)
                         ? rev_addr : {xw_req_in.pointer[15:1], 1'b0};
            next_xw_wb = rev_addr;
        end else if (xw_hit) begin
            next_xw_ea = wrap(xw_raw[31:16], x_circular_start, x_circular_end, 1'b0);
            next_xw_wb = wrap(xw_raw[15:0], x_circular_start, x_circular_end, 1'b0);
        end else begin
            next_xw_ea = xw_raw[31:16];
            next_xw_wb = xw_raw[15:0];
        end
    end

    // Y unit, word-sized data assumed
    always_comb begin
        next_y_ea = y_hit ? wrap(y_raw[31:16], y_circular_start, y_circular_end, 1'b1)
                          : y_raw[31:16];
        next_y_wb = y_hit ? wrap(y_raw[15:0], y_circular_start, y_circular_end, 1'b1)
                          : y_raw[15:0];
    end

    // register writes; control bits steer the address units
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            x_circular_start         <= `MBA_RST_WORD;
            x_circular_end           <= `MBA_RST_WORD;
            y_circular_start         <= `MBA_RST_WORD;
            y_circular_end           <= `MBA_RST_WORD;
            circular_reverse_control <= `MBA_RST_CONTROL;
            reverse_pivot_control    <= `MBA_RST_WORD;
            program_table_page       <= `MBA_RST_PAGE;
            program_window_page      <= `MBA_RST_PAGE;
        end else if (ce_in && reg_wr_in && !reg_addr_in[3]) begin
            case (reg_addr_in[2:0])
                `MBA_REG_X_START:     x_circular_start         <= reg_wdata_in;
                `MBA_REG_X_END:       x_circular_end           <= reg_wdata_in;
                `MBA_REG_Y_START:     y_circular_start         <= reg_wdata_in;
                `MBA_REG_Y_END:       y_circular_end           <= reg_wdata_in;
                `MBA_REG_CONTROL:     circular_reverse_control <= reg_wdata_in;
                `MBA_REG_PIVOT:       reverse_pivot_control    <= reg_wdata_in;
                `MBA_REG_TABLE_PAGE:  program_table_page       <= reg_wdata_in[7:0];
                `MBA_REG_WINDOW_PAGE: program_window_page      <= reg_wdata_in[7:0];
                default: begin
                end
            endcase
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (ce_in) begin
            reg_rdata_out <= 16'h0000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    {1'b0, `MBA_REG_X_START}:     reg_rdata_out <= x_circular_start;
                    {1'b0, `MBA_REG_X_END}:       reg_rdata_out <= x_circular_end;
                    {1'b0, `MBA_REG_Y_START}:     reg_rdata_out <= y_circular_start;
                    {1'b0, `MBA_REG_Y_END}:       reg_rdata_out <= y_circular_end;
                    {1'b0, `MBA_REG_CONTROL}:     reg_rdata_out <= circular_reverse_control;
                    {1'b0, `MBA_REG_PIVOT}:       reg_rdata_out <= reverse_pivot_control;
                    {1'b0, `MBA_REG_TABLE_PAGE}:  reg_rdata_out <= {8'h00, program_table_page};
                    {1'b0, `MBA_REG_WINDOW_PAGE}: reg_rdata_out <= {8'h00, program_window_page};
                    `MBA_REG_STATUS_ADDR:         reg_rdata_out <= wrap_count;
                    default:                      reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end

    // corrected address answers, registered one cycle
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            xr_rsp_out <= '0;
            xw_rsp_out <= '0;
            y_rsp_out  <= '0;
        end else if (ce_in) begin
            xr_rsp_out <= '{xr_req_in.valid, next_xr_ea,
                            xr_req_in.valid && modifies(xr_req_in.mode), next_xr_wb};
            xw_rsp_out <= '{xw_req_in.valid, next_xw_ea,
                            xw_req_in.valid && modifies(xw_req_in.mode), next_xw_wb};
            y_rsp_out  <= '{y_req_in.valid, next_y_ea,
                            y_req_in.valid && modifies(y_req_in.mode), next_y_wb};
        end
    end

    // counts cycles in which the X modulo unit changed the X read or X write address
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wrap_count <= 16'h0000;
        end else if (ce_in && ((xr_hit && next_xr_ea != xr_raw[31:16])
                            || (xw_hit && next_xw_ea != xw_raw[31:16]))) begin
            wrap_count <= wrap_count + 16'h0001;
        end
    end

    // program space address; table access wins over the window
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prog_addr_out     <= 24'h000000;
            prog_valid_out    <= 1'b0;
            prog_config_out   <= 1'b0;
            prog_low_word_out <= 1'b0;
            window_fault_out  <= 1'b0;
        end else if (ce_in) begin
            prog_valid_out    <= 1'b0;
            prog_config_out   <= 1'b0;
            prog_low_word_out <= 1'b0;
            window_fault_out  <= 1'b0;
            if (table_req_in) begin
                prog_addr_out   <= {program_table_page, table_ea_in};
                prog_valid_out  <= 1'b1;
                prog_config_out <= program_table_page[7];
            end else if (window_req_in && window_ea_in[15] && program_window_enable_in) begin
                if (window_wr_in) begin
                    window_fault_out <= 1'b1;
                end else begin
                    prog_addr_out     <= {1'b0, program_window_page, window_ea_in[14:0]};
                    prog_valid_out    <= 1'b1;
                    prog_low_word_out <= 1'b1;
                end
            end
        end
    end

    // a reversed write always lands on an even byte
    property p_rev_even;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && rev_on) |=> (xw_rsp_out.wb_value[0] == 1'b0);
    endproperty
    a_rev_even: assert property (p_rev_even) else $error("reversed address odd");

    // offset mode never writes back
    property p_no_wb_offset;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && xr_req_in.mode == mba_pkg::MBA_MODE_OFFSET) |=> !xr_rsp_out.write_back;
    endproperty
    a_no_wb_offset: assert property (p_no_wb_offset) else $error("offset mode wrote back");

    // Y answers are even whenever the Y buffer corrects
    property p_y_even;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && y_hit) |=> (y_rsp_out.ea[0] == 1'b0);
    endproperty
    a_y_even: assert property (p_y_even) else $error("y modulo address odd");

    // corrected X read stays inside the buffer
    property p_xr_inside;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && xr_hit && x_circular_start <= x_circular_end
         && $stable(x_circular_start) && $stable(x_circular_end)
         && xr_raw[31:16] <= x_circular_end + (x_circular_end - x_circular_start)
         && xr_raw[31:16] >= x_circular_start)
        |=> (xr_rsp_out.ea >= x_circular_start && xr_rsp_out.ea <= x_circular_end);
    endproperty
    a_xr_inside: assert property (p_xr_inside) else $error("x read outside buffer");

    // byte writes keep the ordinary address and update
    property p_byte_plain;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && xw_req_in.valid && xw_req_in.byte_op && !xw_hit) |=>
            ({xw_rsp_out.ea, xw_rsp_out.wb_value} == $past(xw_raw));
    endproperty
    a_byte_plain: assert property (p_byte_plain) else $error("byte write reversed");

    // reversal blocks modulo on the write unit
    property p_rev_prio;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && rev_on) |=> (xw_rsp_out.wb_value == $past(rev_addr));
    endproperty
    a_rev_prio: assert property (p_rev_prio) else $error("modulo active with reversal");

    // table address carries the page on top
    property p_table;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && table_req_in) |=>
            (prog_valid_out && prog_addr_out == {$past(program_table_page), $past(table_ea_in)});
    endproperty
    a_table: assert property (p_table) else $error("table address wrong");

    // window stays user space and needs its enable
    property p_window;
        @(posedge mclk_in) disable iff (!nrst_in)
        (ce_in && !table_req_in && window_req_in && !program_window_enable_in) |=>
            !prog_valid_out;
    endproperty
    a_window: assert property (p_window) else $error("window read while disabled");

    // window address is never in configuration space
    property p_window_user;
        @(posedge mclk_in) disable iff (!nrst_in)
        prog_low_word_out |-> (prog_addr_out[23] == 1'b0 && !prog_config_out);
    endproperty
    a_window_user: assert property (p_window_user) else $error("window left user space");

endmodule : mba_agu

`default_nettype wire

// [tb/mba_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
// stand-in for the execution pipeline: one address request per call
module mba_core_model (
    // clock
    input  wire logic             mclk_in,
    // requests toward the x read, x write and y units
    output var mba_pkg::mba_req_t xr_req_out,
    output var mba_pkg::mba_req_t xw_req_out,
    output var mba_pkg::mba_req_t y_req_out
);
    initial begin
        xr_req_out = '0;
        xw_req_out = '0;
        y_req_out  = '0;
    end
    // unit 0 x read, 1 x write, 2 y
    task automatic put(input int u, input mba_pkg::mba_req_t r);
        case (u)
            0: xr_req_out <= r;
            1: xw_req_out <= r;
            default: y_req_out <= r;
        endcase
    endtask : put
    // request held for exactly one taking edge; reversed buffers sit on
    // aligned starts and no pivot write is followed at once by a
    // reversed-pointer read
    task automatic issue(input int u, input logic [3:0] sel, input logic [15:0] ptr,
                         input logic [15:0] md, input mba_pkg::mba_mode_t mode,
                         input logic bop);
        mba_pkg::mba_req_t r;
        r = {1'b1, sel, ptr, md, mode, bop};
        @(posedge mclk_in);
        put(u, r);
        @(posedge mclk_in);
        // released fields do not keep their last value
        r = ~r;
        r.valid = 1'b0;
        put(u, r);
    endtask : issue
endmodule : mba_core_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
    // design signals
    logic              mclk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1, win_en = 1'b0;
    logic [3:0]        reg_addr_in = 4'h0;
    logic [15:0]       reg_wdata_in = 16'h0000, reg_rdata_out, tea = 16'h0000, wea = 16'h0000;
    logic              reg_wr_in = 1'b0, reg_rd_in = 1'b0, treq = 1'b0, wreq = 1'b0, wwr = 1'b0;
    mba_pkg::mba_req_t xr_q, xw_q, y_q;
    mba_pkg::mba_rsp_t xr_s, xw_s, y_s, s;
    logic [23:0]       pa;
    logic              pv, pc, pl, pf;
    int                fails = 0, comparisons = 0;
    always #2.5 mclk_in = ~mclk_in;
    mba_core_model i_core (.mclk_in(mclk_in), .xr_req_out(xr_q), .xw_req_out(xw_q), .y_req_out(y_q));
    mba_agu i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .program_window_enable_in(win_en), .xr_req_in(xr_q),
        .xw_req_in(xw_q), .y_req_in(y_q), .xr_rsp_out(xr_s), .xw_rsp_out(xw_s), .y_rsp_out(y_s),
        .table_req_in(treq), .table_ea_in(tea), .window_req_in(wreq), .window_wr_in(wwr),
        .window_ea_in(wea), .prog_addr_out(pa), .prog_valid_out(pv), .prog_config_out(pc),
        .prog_low_word_out(pl), .window_fault_out(pf));
    // single place where the run ends
    task automatic print_verdict;
        if (fails == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0; reg_wdata_in <= ~d;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        reg_addr_in <= a; reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 chk("reg_rdata_out", {8'h00, e}, {8'h00, reg_rdata_out});
    endtask : rd
    // one pipeline request, answer one cycle later
    task automatic xq(input int u, input logic [3:0] sel, input logic [15:0] p, input logic [15:0] m,
                      input mba_pkg::mba_mode_t md, input logic b, input logic [15:0] ea,
                      input logic wb, input logic [15:0] wv);
        i_core.issue(u, sel, p, m, md, b);
        #1 s = (u == 0) ? xr_s : (u == 1) ? xw_s : y_s;
        chk("rsp_valid_wb", {22'h0, 2'b10 | wb}, {22'h0, s.valid, s.write_back});
        chk("rsp_ea", {8'h00, ea}, {8'h00, s.ea});
        if (wb) chk("rsp_wb_value", {8'h00, wv}, {8'h00, s.wb_value});
    endtask : xq
    // program address request; f = valid, config, low word, fault
    task automatic pg(input logic t, input logic w, input logic ww, input logic [15:0] ea,
                      input logic [23:0] a, input logic [3:0] f);
        @(posedge mclk_in);
        treq <= t; wreq <= w; wwr <= ww; tea <= ea; wea <= ea;
        @(posedge mclk_in);
        treq <= 1'b0; wreq <= 1'b0; wwr <= 1'b0; tea <= ~ea; wea <= ~ea;
        #1 chk("prog_flags", {20'h0, f}, {20'h0, pv, pc, pl, pf});
        if (f[3]) chk("prog_addr_out", a, pa);
    endtask : pg
    // guard against a hang
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
    // pipeline modes used by the scenarios
    localparam mba_pkg::mba_mode_t m_post_inc = mba_pkg::MBA_MODE_POST_INC;
    localparam mba_pkg::mba_mode_t m_post_dec = mba_pkg::MBA_MODE_POST_DEC;
    localparam mba_pkg::mba_mode_t m_pre_inc  = mba_pkg::MBA_MODE_PRE_INC;
    localparam mba_pkg::mba_mode_t m_pre_dec  = mba_pkg::MBA_MODE_PRE_DEC;
    localparam mba_pkg::mba_mode_t m_offset   = mba_pkg::MBA_MODE_OFFSET;
    localparam mba_pkg::mba_mode_t m_direct   = mba_pkg::MBA_MODE_DIRECT;
    // main sequence
    initial begin
        repeat (6) @(posedge mclk_in);
        nrst_in <= 1'b1;
        rd(4'h4, 16'h0fff);
        rd(4'hf, 16'h0000);
        wr(4'h0, 16'h1100); wr(4'h1, 16'h1163); wr(4'h4, 16'h8001);
        rd(4'h0, 16'h1100); rd(4'h1, 16'h1163);
        xq(0, 4'h1, 16'h1162, 16'h0002, m_post_inc, 0, 16'h1162, 1, 16'h1100);
        xq(1, 4'h1, 16'h1162, 16'h0002, m_post_inc, 0, 16'h1162, 1, 16'h1100);
        xq(0, 4'h1, 16'h1160, 16'h0008, m_post_inc, 0, 16'h1160, 1, 16'h1104);
        xq(0, 4'h1, 16'h1100, 16'h0002, m_post_dec, 0, 16'h1100, 1, 16'h1162);
        xq(0, 4'h1, 16'h1160, 16'h0008, m_offset, 0, 16'h1104, 0, 16'h0000);
        xq(0, 4'h1, 16'h1162, 16'h0002, m_pre_inc, 0, 16'h1100, 1, 16'h1100);
        xq(0, 4'h2, 16'h1162, 16'h0002, m_post_inc, 0, 16'h1162, 1, 16'h1164);
        wr(4'h4, 16'h0001);
        xq(0, 4'h1, 16'h1162, 16'h0002, m_post_inc, 0, 16'h1162, 1, 16'h1164);
        wr(4'h2, 16'h2000); wr(4'h3, 16'h200f); wr(4'h4, 16'h4010);
        xq(2, 4'h1, 16'h200e, 16'h0002, m_post_inc, 0, 16'h200e, 1, 16'h2000);
        // odd address inside the Y buffer comes out even
        xq(2, 4'h1, 16'h2011, 16'h0002, m_pre_dec, 0, 16'h200e, 1, 16'h200e);
        wr(4'h4, 16'h0f1f);
        xq(2, 4'h1, 16'h200e, 16'h0002, m_post_inc, 0, 16'h200e, 1, 16'h2010);
        wr(4'h4, 16'h8304); wr(4'h5, 16'h8008);
        xq(1, 4'h3, 16'h1000, 16'h0002, m_post_inc, 0, 16'h1000, 1, 16'h1010);
        xq(1, 4'h3, 16'h1010, 16'h0002, m_pre_inc, 0, 16'h1008, 1, 16'h1008);
        xq(1, 4'h3, 16'h1000, 16'h0002, m_post_inc, 1, 16'h1000, 1, 16'h1002);
        xq(1, 4'h3, 16'h1000, 16'h0002, m_post_dec, 0, 16'h1000, 1, 16'h0ffe);
        xq(0, 4'h3, 16'h1000, 16'h0002, m_post_inc, 0, 16'h1000, 1, 16'h1002);
        wr(4'h5, 16'h0008);
        xq(1, 4'h3, 16'h1000, 16'h0002, m_post_inc, 0, 16'h1000, 1, 16'h1002);
        wr(4'h5, 16'h8008); wr(4'h4, 16'h8f04);
        xq(1, 4'h3, 16'h1000, 16'h0002, m_post_inc, 0, 16'h1000, 1, 16'h1002);
        wr(4'h4, 16'h8303);
        xq(0, 4'h3, 16'h1162, 16'h0002, m_post_inc, 0, 16'h1162, 1, 16'h1100);
        xq(1, 4'h3, 16'h1162, 16'h0002, m_post_inc, 0, 16'h1162, 1, 16'h1172);
        xq(0, 4'h3, 16'h1100, 16'h0002, m_pre_dec, 0, 16'h1162, 1, 16'h1162);
        xq(0, 4'h3, 16'h1170, 16'h0002, m_direct, 0, 16'h1170, 0, 16'h0000);
        // offset, pre-increment and pre-decrement each moved an X address
        rd(4'h8, 16'h0003);
        wr(4'h6, 16'h0085); wr(4'h7, 16'h0012);
        rd(4'h7, 16'h0012);
        @(posedge mclk_in) win_en <= 1'b1;
        pg(1, 0, 0, 16'h1234, 24'h851234, 4'b1100);
        wr(4'h6, 16'h0005);
        pg(1, 0, 0, 16'h1234, 24'h051234, 4'b1000);
        pg(0, 1, 0, 16'h8abc, 24'h090abc, 4'b1010);
        pg(0, 1, 0, 16'h0abc, 24'h000000, 4'b0000);
        pg(0, 1, 1, 16'h8abc, 24'h000000, 4'b0001);
        @(posedge mclk_in) win_en <= 1'b0;
        pg(0, 1, 0, 16'h8abc, 24'h000000, 4'b0000);
        // a write while the clock enable is low must not land
        @(posedge mclk_in) ce_in <= 1'b0;
        wr(4'h6, 16'h00aa);
        ce_in <= 1'b1;
        rd(4'h6, 16'h0005);
        // a second reset restores the disabled control and clears the count
        @(posedge mclk_in) nrst_in <= 1'b0;
        @(posedge mclk_in) nrst_in <= 1'b1;
        rd(4'h4, 16'h0fff);
        rd(4'h8, 16'h0000);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
